// ### logic/dotm_top.sv
// Output terminal mapper: switch outputs, pulse output and two analog outputs.
// Drive status inputs come from logic on clk_i and are used unsynchronised.
`timescale 1ns/1ps
`include "dotm_consts.svh"

module dotm_top
  import dotm_pkg::*;
#(
  parameter int unsigned STEP_CYCLES = `DOTM_STEP_CYCLES
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         reset_i,
  // Register port.
  input  wire logic [7:0]   addr_i,
  input  wire logic [31:0]  wdata_i,
  input  wire logic         wr_i,
  input  wire logic         rd_i,
  output logic      [31:0]  rdata_o,
  output logic              irq_o,
  // Drive status.
  input  wire logic         running_i,
  input  wire logic         reverse_i,
  input  wire logic         fault_i,
  input  wire logic         load_zero_i,
  input  wire logic         freq_at_low_i,
  input  wire logic [15:0]  run_time_i,
  input  wire logic [15:0]  analog_input_one_i,
  input  wire logic [15:0]  heatsink_temp_reading_i,
  input  wire logic [15:0]  motor_temp_monitor_i,
  // Sixteen normalised source quantities, 16 bits each, full range 0xffff.
  input  wire logic [255:0] src_values_i,
  // Terminals; a switch output high means connected to output_common.
  output logic              transistor_output_two_o,
  output logic              relay_output_one_o,
  output logic              relay_output_two_o,
  output logic              transistor_output_one_o,
  output logic              expansion_switch_output_o,
  output logic              pulse_freq_output_o,
  output logic      [13:0]  analog_output_one_o,
  output logic      [13:0]  analog_output_two_o
);

  localparam int NOUT = 5;

  function automatic dotm_word_t pick_src(input logic [255:0] v,
                                          input logic [3:0]   s);
    pick_src = v[{4'h0, s} * 8'd16 +: 16];
  endfunction

  function automatic dotm_word_t clamp_s(input dotm_word_t v,
                                         input dotm_word_t lim);
    if ($signed(v) > $signed(lim))
      clamp_s = lim;
    else if ($signed(v) < -$signed(lim))
      clamp_s = -lim;
    else
      clamp_s = v;
  endfunction

  // Standard value is the source scaled to 0..10000 (0.01 % units).
  function automatic logic [13:0] ao_calc(input logic signed [15:0] g,
                                          input logic signed [15:0] b,
                                          input dotm_word_t q);
    logic        [29:0] xp;
    logic signed [31:0] y;
    xp = 30'(q) * 30'd10000;
    y = (32'(g) * $signed({18'd0, xp[29:16]})) / 32'sd100
        + 32'(b) * 32'sd10; // RULE13 RULE14
    if (y < 32'sd0)
      ao_calc = 14'h0000;
    else if (y > 32'sd10000)
      ao_calc = 14'(`DOTM_AO_FULL);
    else
      ao_calc = y[13:0];
  endfunction

  // Registers.
  logic [7:0]  func_reg [NOUT];
  dotm_word_t  delay_reg [NOUT];
  logic [4:0]  pol_reg;
  dotm_word_t  max_pulse_reg;
  logic [3:0]  pulse_src_reg;
  logic [3:0]  ao1_src_reg;
  logic [3:0]  ao2_src_reg;
  dotm_word_t  ao1_gain_reg;
  dotm_word_t  ao1_off_reg;
  dotm_word_t  ao2_gain_reg;
  dotm_word_t  ao2_off_reg;
  logic        timing_en_reg;
  dotm_word_t  timing_val_reg;
  dotm_word_t  in_low_reg;
  dotm_word_t  in_high_reg;
  dotm_word_t  mod_temp_reg;
  dotm_word_t  mot_temp_reg;
  dotm_word_t  run_thr_reg;
  logic [4:0]  irq_stat_reg;
  logic [4:0]  irq_mask_reg;
  logic [31:0] rdata_reg;
  logic        irq_reg;

  // Switch output state.
  logic [NOUT-1:0] cond_w;
  logic [NOUT-1:0] act_reg;
  logic [NOUT-1:0] term_reg;
  logic [31:0]     sub_reg [NOUT];
  dotm_word_t      tenth_reg [NOUT];

  // Pulse and analog state.
  logic [39:0] phase_reg;
  dotm_word_t  pfreq_reg;
  logic        pulse_reg;
  logic [13:0] ao1_reg;
  logic [13:0] ao2_reg;

  // Address decode.
  wire        wr_per   = wr_i && addr_i < `DOTM_DELAY_BASE + 8'h14;
  wire [2:0]  per_idx  = addr_i < `DOTM_DELAY_BASE ?
                         3'(addr_i[7:2]) : 3'(addr_i[7:2] - 6'h05);
  wire        per_del  = addr_i >= `DOTM_DELAY_BASE;
  wire [15:0] wlo      = wdata_i[15:0];
  wire [15:0] wr_delay = wlo > `DOTM_DELAY_MAX ? `DOTM_DELAY_MAX : wlo;
  wire [15:0] wr_pulse = wlo < `DOTM_MAX_PULSE_MIN ? `DOTM_MAX_PULSE_MIN :
                         wlo > `DOTM_MAX_PULSE_MAX ? `DOTM_MAX_PULSE_MAX :
                         wlo; // RULE11
  wire        clr_stat = wr_i && addr_i == `DOTM_IRQ_STATUS;

  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NOUT; i++) begin
        func_reg[i]  <= 8'h00;
        delay_reg[i] <= 16'h0000;
      end
      pol_reg        <= 5'h00;
      max_pulse_reg  <= `DOTM_MAX_PULSE_RST;
      pulse_src_reg  <= 4'h0;
      ao1_src_reg    <= `DOTM_AO1_SRC_RST;
      ao2_src_reg    <= `DOTM_AO2_SRC_RST;
      ao1_gain_reg   <= `DOTM_GAIN_RST;
      ao2_gain_reg   <= `DOTM_GAIN_RST;
      ao1_off_reg    <= 16'h0000;
      ao2_off_reg    <= 16'h0000;
      timing_en_reg  <= 1'b0;
      timing_val_reg <= 16'h0000;
      in_low_reg     <= 16'h0000;
      in_high_reg    <= 16'hffff;
      mod_temp_reg   <= 16'hffff;
      mot_temp_reg   <= 16'hffff;
      run_thr_reg    <= 16'hffff;
      irq_mask_reg   <= 5'h00;
    end else if (wr_i) begin
      if (wr_per && !per_del)
        func_reg[per_idx] <= wdata_i[7:0];
      if (wr_per && per_del)
        delay_reg[per_idx] <= wr_delay; // RULE15
      case (addr_i)
        `DOTM_POLARITY:     pol_reg        <= wdata_i[4:0]; // RULE16
        `DOTM_MAX_PULSE:    max_pulse_reg  <= wr_pulse;
        `DOTM_PULSE_SRC:    pulse_src_reg  <= wdata_i[3:0];
        `DOTM_AO1_SRC:      ao1_src_reg    <= wdata_i[3:0];
        `DOTM_AO2_SRC:      ao2_src_reg    <= wdata_i[3:0];
        `DOTM_AO1_GAIN:     ao1_gain_reg   <= clamp_s(wlo, `DOTM_GAIN_LIMIT);
        `DOTM_AO1_OFFSET:   ao1_off_reg    <= clamp_s(wlo, `DOTM_OFFSET_LIMIT);
        `DOTM_AO2_GAIN:     ao2_gain_reg   <= clamp_s(wlo, `DOTM_GAIN_LIMIT);
        `DOTM_AO2_OFFSET:   ao2_off_reg    <= clamp_s(wlo, `DOTM_OFFSET_LIMIT);
        `DOTM_TIMING_EN:    timing_en_reg  <= wdata_i[0];
        `DOTM_TIMING_VALUE: timing_val_reg <= wlo;
        `DOTM_IN_LOW:       in_low_reg     <= wlo;
        `DOTM_IN_HIGH:      in_high_reg    <= wlo;
        `DOTM_MODULE_TEMP:  mod_temp_reg   <= wlo;
        `DOTM_MOTOR_TEMP:   mot_temp_reg   <= wlo;
        `DOTM_RUN_TIME:     run_thr_reg    <= wlo;
        `DOTM_IRQ_MASK:     irq_mask_reg   <= wdata_i[4:0];
        default: ;
      endcase
    end
  end

  // Read mux; unmapped offsets read as zero.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (addr_i < `DOTM_DELAY_BASE)
      rd_mux = {24'h0, func_reg[per_idx]};
    else if (addr_i < `DOTM_POLARITY)
      rd_mux = {16'h0, delay_reg[per_idx]};
    else
      case (addr_i)
        `DOTM_POLARITY:     rd_mux = {27'h0, pol_reg};
        `DOTM_MAX_PULSE:    rd_mux = {16'h0, max_pulse_reg};
        `DOTM_PULSE_SRC:    rd_mux = {28'h0, pulse_src_reg};
        `DOTM_AO1_SRC:      rd_mux = {28'h0, ao1_src_reg};
        `DOTM_AO2_SRC:      rd_mux = {28'h0, ao2_src_reg};
        `DOTM_AO1_GAIN:     rd_mux = {16'h0, ao1_gain_reg};
        `DOTM_AO1_OFFSET:   rd_mux = {16'h0, ao1_off_reg};
        `DOTM_AO2_GAIN:     rd_mux = {16'h0, ao2_gain_reg};
        `DOTM_AO2_OFFSET:   rd_mux = {16'h0, ao2_off_reg};
        `DOTM_TIMING_EN:    rd_mux = {31'h0, timing_en_reg};
        `DOTM_TIMING_VALUE: rd_mux = {16'h0, timing_val_reg};
        `DOTM_IN_LOW:       rd_mux = {16'h0, in_low_reg};
        `DOTM_IN_HIGH:      rd_mux = {16'h0, in_high_reg};
        `DOTM_MODULE_TEMP:  rd_mux = {16'h0, mod_temp_reg};
        `DOTM_MOTOR_TEMP:   rd_mux = {16'h0, mot_temp_reg};
        `DOTM_RUN_TIME:     rd_mux = {16'h0, run_thr_reg};
        `DOTM_IRQ_STATUS:   rd_mux = {27'h0, irq_stat_reg};
        `DOTM_IRQ_MASK:     rd_mux = {27'h0, irq_mask_reg};
        `DOTM_TERM_STATE:   rd_mux = {27'h0, act_reg};
        default:            rd_mux = 32'h0000_0000;
      endcase
  end

  always_ff @(posedge clk_i) begin
    if (reset_i)
      rdata_reg <= 32'h0000_0000;
    else if (rd_i)
      rdata_reg <= rd_mux;
    else
      rdata_reg <= 32'h0000_0000;
  end

  // Status condition for each switch output by its function code.
  // Codes other than those below give an inactive status.
  function automatic logic cond_of(input logic [7:0] code);
    case (code)
      DOTM_FN_NONE:      cond_of = 1'b0; // RULE1
      DOTM_FN_RUNNING:   cond_of = running_i; // RULE1
      DOTM_FN_TIMING:    cond_of = timing_en_reg &&
                                   run_time_i >= timing_val_reg; // RULE2
      DOTM_FN_IN_LIMIT:  cond_of = analog_input_one_i > in_high_reg ||
                                   analog_input_one_i < in_low_reg; // RULE3
      DOTM_FN_LOAD_ZERO: cond_of = load_zero_i; // RULE4
      DOTM_FN_REVERSE:   cond_of = running_i && reverse_i; // RULE5
      DOTM_FN_MOD_TEMP:  cond_of = heatsink_temp_reading_i >=
                                   mod_temp_reg; // RULE6
      DOTM_FN_LOW_LIMIT: cond_of = freq_at_low_i || !running_i; // RULE7
      DOTM_FN_ALARM:     cond_of = fault_i && running_i; // RULE8
      DOTM_FN_MOT_TEMP:  cond_of = motor_temp_monitor_i >=
                                   mot_temp_reg; // RULE9
      DOTM_FN_RUN_TIME:  cond_of = run_time_i > run_thr_reg; // RULE10
      default:           cond_of = 1'b0;
    endcase
  endfunction

  // Delay is counted in 0.1 s steps; a zero delay passes on the next edge.
  for (genvar i = 0; i < NOUT; i++) begin : g_sw
    // A process, so that status inputs read by the function wake it.
    always_comb cond_w[i] = cond_of(func_reg[i]);
    wire expire = tenth_reg[i] >= delay_reg[i];
    wire step   = sub_reg[i] == STEP_CYCLES - 1;
    always_ff @(posedge clk_i) begin
      if (reset_i) begin
        act_reg[i]   <= 1'b0;
        sub_reg[i]   <= 32'h0000_0000;
        tenth_reg[i] <= 16'h0000;
      end else if (cond_w[i] == act_reg[i]) begin
        sub_reg[i]   <= 32'h0000_0000; // RULE18
        tenth_reg[i] <= 16'h0000; // RULE18
      end else if (expire) begin
        act_reg[i]   <= cond_w[i]; // RULE15
        sub_reg[i]   <= 32'h0000_0000;
        tenth_reg[i] <= 16'h0000;
      end else if (step) begin
        sub_reg[i]   <= 32'h0000_0000;
        tenth_reg[i] <= tenth_reg[i] + 16'h0001; // RULE15
      end else begin
        sub_reg[i]   <= sub_reg[i] + 32'h0000_0001;
      end
    end
    // Terminal is connected when active, or when inactive if inverted.
    always_ff @(posedge clk_i) begin
      if (reset_i)
        term_reg[i] <= 1'b0;
      else
        term_reg[i] <= act_reg[i] ^ pol_reg[i]; // RULE17
    end
  end

  // Interrupt: each change of an output's active state is an event; write one to clear.
  logic [4:0] act_d_reg;
  wire  [4:0] ev = act_reg ^ act_d_reg;
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      act_d_reg    <= 5'h00;
      irq_stat_reg <= 5'h00;
      irq_reg      <= 1'b0;
    end else begin
      act_d_reg    <= act_reg;
      // A change that lands in the clearing cycle is kept.
      irq_stat_reg <= (irq_stat_reg & ~(clr_stat ? wdata_i[4:0] : 5'h00))
                      | ev;
      irq_reg      <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  // Pulse output: frequency from 0.01 kHz up to the maximum setting.
  wire [15:0] psrc = pick_src(src_values_i, pulse_src_reg); // RULE12
  wire [31:0] pspan = 32'(psrc) * 32'(max_pulse_reg - 16'h0001);
  wire [15:0] pfreq_next = 16'h0001 + pspan[31:16]; // RULE11
  wire [39:0] pstep = 40'(pfreq_reg) * 40'(`DOTM_PHASE_PER_UNIT);
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      pfreq_reg <= 16'h0001;
      phase_reg <= 40'h00_0000_0000;
      pulse_reg <= 1'b0;
    end else begin
      pfreq_reg <= pfreq_next;
      phase_reg <= phase_reg + pstep;
      pulse_reg <= phase_reg[39];
    end
  end

  // Analog outputs.
  wire [15:0] a1src = pick_src(src_values_i, ao1_src_reg); // RULE12
  wire [15:0] a2src = pick_src(src_values_i, ao2_src_reg); // RULE12
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ao1_reg <= 14'h0000;
      ao2_reg <= 14'h0000;
    end else begin
      ao1_reg <= ao_calc(ao1_gain_reg, ao1_off_reg, a1src);
      ao2_reg <= ao_calc(ao2_gain_reg, ao2_off_reg, a2src);
    end
  end

  assign rdata_o                   = rdata_reg;
  assign irq_o                     = irq_reg;
  assign transistor_output_two_o   = term_reg[0];
  assign relay_output_one_o        = term_reg[1];
  assign relay_output_two_o        = term_reg[2];
  assign transistor_output_one_o   = term_reg[3];
  assign expansion_switch_output_o = term_reg[4];
  assign pulse_freq_output_o       = pulse_reg;
  assign analog_output_one_o       = ao1_reg;
  assign analog_output_two_o       = ao2_reg;

  // Checks on output zero, which shares its logic with the other four.
  sequence s_zero_delay;
    delay_reg[0] == 16'h0000 && cond_w[0] != act_reg[0];
  endsequence

  a_none_code_off: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h00 |-> !cond_w[0]) // RULE1
    else $error("Code zero produced an active status.");
  a_run_follows: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h01 |-> cond_w[0] == running_i) // RULE1
    else $error("Running code does not follow running.");
  a_timing_gate: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h1e && !timing_en_reg |-> !cond_w[0]) // RULE2
    else $error("Timing output active while disabled.");
  a_limit_window: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h1f && analog_input_one_i > in_high_reg
    |-> cond_w[0]) // RULE3
    else $error("Input above limit not flagged.");
  a_low_stop_on: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h25 && !running_i |-> cond_w[0]) // RULE7
    else $error("Lower limit output off while stopped.");
  a_alarm_run: assert property (@(posedge clk_i) disable iff (reset_i)
    func_reg[0] == 8'h26 && !running_i |-> !cond_w[0]) // RULE8
    else $error("Alarm active while stopped.");
  a_zero_delay_pass: assert property (@(posedge clk_i) disable iff (reset_i)
    s_zero_delay |=> act_reg[0] == $past(cond_w[0])) // RULE15
    else $error("Zero delay did not pass the status at once.");
  a_delay_holds: assert property (@(posedge clk_i) disable iff (reset_i)
    delay_reg[0] != 16'h0000 && cond_w[0] != act_reg[0]
    && tenth_reg[0] == 16'h0000 |=> $stable(act_reg[0])) // RULE15
    else $error("Terminal changed before its delay.");
  a_cancel_clear: assert property (@(posedge clk_i) disable iff (reset_i)
    cond_w[0] == act_reg[0] |=> tenth_reg[0] == 16'h0000) // RULE18
    else $error("Returned status did not cancel the delay.");
  a_polarity_term: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 term_reg[0] == ($past(act_reg[0]) ^ $past(pol_reg[0]))) // RULE17
    else $error("Terminal level does not match polarity.");
  a_pulse_range: assert property (@(posedge clk_i) disable iff (reset_i)
    ##1 pfreq_reg >= 16'h0001 && pfreq_reg <= max_pulse_reg
    || $changed(max_pulse_reg)) // RULE11
    else $error("Pulse frequency outside its range.");
  a_ao_limit: assert property (@(posedge clk_i) disable iff (reset_i)
    ao1_reg <= 14'(`DOTM_AO_FULL) && ao2_reg <= 14'(`DOTM_AO_FULL)) // RULE13
    else $error("Analog output above full scale.");

endmodule // dotm_top

// ### pkg/dotm_consts.svh
// Constants of the drive output terminal mapper: offsets, limits, resets and
// timing. Assumes a 100 MHz system clock and a plain register port.
// Summary of operation
// RULE1: Code 0 gives no function; code 1 is on while the drive runs.
// RULE2: Code 30 turns on when timing is enabled and run time reaches it.
// RULE3: Code 31 is on while input one is above high or below low limit.
// RULE4: Code 32 turns on when the load has dropped to zero.
// RULE5: Code 33 shows that the drive runs in reverse.
// RULE6: Code 35 turns on when heatsink temperature reaches its threshold.
// RULE7: Code 37 is on at the lower frequency limit and while stopped.
// RULE8: Code 38 raises an alarm while a fault exists and the drive runs.
// RULE9: Code 39 turns on when motor temperature reaches its warning level.
// RULE10: Code 40 turns on when present run time exceeds its threshold.
// RULE11: Pulse output spans 0.01 kHz to a maximum of 0.01 to 100 kHz.
// RULE12: Pulse and analog outputs pick one of sixteen sources, scaled.
// RULE13: Analog output equals gain times standard value plus offset.
// RULE14: Offset spans minus to plus one hundred percent of full scale.
// RULE15: Each switch output delays its changes by 0.0 to 3600.0 seconds.
// RULE16: Five polarity digits select one bit for each switch output.
// RULE17: Polarity 0 connects to common when active; 1 inverts that.
// RULE18: A status that returns before its delay ends cancels the change.
`ifndef DOTM_CONSTS_SVH
`define DOTM_CONSTS_SVH

// Register byte offsets; the five per-output registers step by four.
`define DOTM_FUNC_BASE     8'h00
`define DOTM_DELAY_BASE    8'h14
`define DOTM_POLARITY      8'h28
`define DOTM_MAX_PULSE     8'h2c
`define DOTM_PULSE_SRC     8'h30
`define DOTM_AO1_SRC       8'h34
`define DOTM_AO2_SRC       8'h38
`define DOTM_AO1_GAIN      8'h3c
`define DOTM_AO1_OFFSET    8'h40
`define DOTM_AO2_GAIN      8'h44
`define DOTM_AO2_OFFSET    8'h48
`define DOTM_TIMING_EN     8'h4c
`define DOTM_TIMING_VALUE  8'h50
`define DOTM_IN_LOW        8'h54
`define DOTM_IN_HIGH       8'h58
`define DOTM_MODULE_TEMP   8'h5c
`define DOTM_MOTOR_TEMP    8'h60
`define DOTM_RUN_TIME      8'h64
`define DOTM_IRQ_STATUS    8'h68
`define DOTM_IRQ_MASK      8'h6c
`define DOTM_TERM_STATE    8'h70

// Reset values and setting limits.
`define DOTM_MAX_PULSE_RST 16'h1388
`define DOTM_MAX_PULSE_MIN 16'h0001
`define DOTM_MAX_PULSE_MAX 16'h2710
`define DOTM_GAIN_RST      16'h0064
`define DOTM_GAIN_LIMIT    16'h03e8
`define DOTM_OFFSET_LIMIT  16'h03e8
`define DOTM_DELAY_MAX     16'h8ca0
`define DOTM_AO1_SRC_RST   4'h0
`define DOTM_AO2_SRC_RST   4'h1
`define DOTM_AO_FULL       16'h2710

// Timing: the delay step is 0.1 s, 100 ms at 10 ns per clock.
`define DOTM_CLK_PERIOD_NS 10
`define DOTM_DELAY_STEP_MS 100
`define DOTM_STEP_CYCLES (`DOTM_DELAY_STEP_MS * 1000000 / `DOTM_CLK_PERIOD_NS)
// Phase step per 0.01 kHz on a 40-bit accumulator: 2^40 / 1e7 clocks.
`define DOTM_PHASE_PER_UNIT 17'h1ad7f

`endif

// ### pkg/dotm_pkg.sv
// Types of the drive output terminal mapper.
// Assumes the constants header is included by the design file.
package dotm_pkg;

  typedef enum logic [7:0] {
    DOTM_FN_NONE      = 8'h00,
    DOTM_FN_RUNNING   = 8'h01,
    DOTM_FN_TIMING    = 8'h1e,
    DOTM_FN_IN_LIMIT  = 8'h1f,
    DOTM_FN_LOAD_ZERO = 8'h20,
    DOTM_FN_REVERSE   = 8'h21,
    DOTM_FN_MOD_TEMP  = 8'h23,
    DOTM_FN_LOW_LIMIT = 8'h25,
    DOTM_FN_ALARM     = 8'h26,
    DOTM_FN_MOT_TEMP  = 8'h27,
    DOTM_FN_RUN_TIME  = 8'h28
  } dotm_func_e;

  typedef logic [15:0] dotm_word_t;

endpackage

// ### verif/dotm_loads.sv
// Far-side load model: a pulse counter on the frequency output terminal.
// Assumes the pulse output is a registered square wave on the system clock.
`timescale 1ns/1ps

module dotm_loads (
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        reset_i,
  // Pulse terminal.
  input  wire logic        pulse_i,
  // Rising edges counted since reset.
  output logic      [31:0] edges_o
);
  logic prev_reg;

  // Sampling on the system clock is enough, the pulse tops out at 100 kHz.
  always_ff @(posedge clk_i) begin
    prev_reg <= pulse_i;
    if (reset_i)
      edges_o <= 32'h0;
    else if (pulse_i && !prev_reg)
      edges_o <= edges_o + 32'h1;
  end
endmodule // dotm_loads

// ### verif/drive_output_terminal_mapper_tb.sv
// Self-checking testbench of the output terminal mapper, one task a scenario.
// Assumes a 100 MHz clock and the delay step shortened to ten clocks.
`timescale 1ns/1ps

module drive_output_terminal_mapper_tb;
  logic         clk_i = 0, reset_i = 1, wr_i = 0, rd_i = 0;
  logic [7:0]   addr_i = 8'h0;
  logic [31:0]  wdata_i = 32'h0, rdata_o, got, pcnt;
  logic         irq_o, run = 0, rev = 0, flt = 0, lz = 0, fl = 0, pls;
  logic [15:0]  rt = 16'h0, ain = 16'h0, hs = 16'h0, mt = 16'h0;
  logic [255:0] src = 256'h0;
  wire  [4:0]   pin;
  logic [13:0]  ao1, ao2;
  int           fails = 0, checks_done = 0;

  dotm_top #(.STEP_CYCLES(10)) uut (.clk_i(clk_i), .reset_i(reset_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rdata_o(rdata_o), .irq_o(irq_o), .running_i(run), .reverse_i(rev),
    .fault_i(flt), .load_zero_i(lz), .freq_at_low_i(fl), .run_time_i(rt),
    .analog_input_one_i(ain), .heatsink_temp_reading_i(hs),
    .motor_temp_monitor_i(mt), .src_values_i(src),
    .transistor_output_two_o(pin[0]), .relay_output_one_o(pin[1]),
    .relay_output_two_o(pin[2]), .transistor_output_one_o(pin[3]),
    .expansion_switch_output_o(pin[4]), .pulse_freq_output_o(pls),
    .analog_output_one_o(ao1), .analog_output_two_o(ao2));
  dotm_loads ld (.clk_i(clk_i), .reset_i(reset_i), .pulse_i(pls),
    .edges_o(pcnt));

  always #5 clk_i = ~clk_i;

  task automatic end_of_test;
    $display("checks %0d fails %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe.
  task automatic rd(input logic [7:0] a);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    #1 got = rdata_o;
  endtask

  // State 0 only runs, 1 sets every condition, 2 is stopped at boundaries.
  task automatic st(input int s);
    @(posedge clk_i);
    run <= s != 2;
    rev <= s != 0;
    flt <= s != 0;
    lz <= s == 1;
    fl <= s == 1;
    rt <= s == 0 ? 16'h63 : s == 1 ? 16'hc9 : 16'hc8;
    ain <= s == 0 ? 16'h1f4 : s == 1 ? 16'h7d0 : 16'h9;
    hs <= s == 1 ? 16'h32 : 16'h31;
    mt <= s == 1 ? 16'h3c : 16'h3b;
  endtask

  task automatic wt(input logic v, output int n);
    n = 0;
    while (pin[1] !== v) begin
      if (n == 60) begin
        fails++;
        end_of_test;
      end
      cyc(1);
      n++;
    end
  endtask

  task automatic t_reset;
    logic [7:0]  a [7] = '{8'h2c, 8'h3c, 8'h40, 8'h38, 8'h28, 8'h18, 8'hfc};
    logic [31:0] e [7] = '{32'h1388, 32'h64, 32'h0, 32'h1, 32'h0, 32'h0,
                           32'h0};
    for (int i = 0; i < 7; i++) begin
      rd(a[i]);
      chk(got, e[i]);
    end
  endtask

  task automatic t_codes;
    logic [7:0] c [11] = '{8'h00, 8'h01, 8'h1e, 8'h1f, 8'h20, 8'h21, 8'h23,
                           8'h25, 8'h26, 8'h27, 8'h28};
    logic [2:0] e [11] = '{3'h0, 3'h3, 3'h6, 3'h6, 3'h2, 3'h2, 3'h2, 3'h6,
                           3'h2, 3'h2, 3'h2};
    wr(8'h50, 32'h64);
    wr(8'h4c, 32'h1);
    wr(8'h58, 32'h3e8);
    wr(8'h54, 32'ha);
    wr(8'h5c, 32'h32);
    wr(8'h60, 32'h3c);
    wr(8'h64, 32'hc8);
    for (int i = 0; i < 11; i++) begin
      wr(8'h00, {24'h0, c[i]});
      for (int s = 0; s < 3; s++) begin
        st(s);
        cyc(3);
        chk(32'(pin[0]), 32'(e[i][s]));
      end
    end
    wr(8'h00, 32'h1e);
    st(1);
    cyc(3);
    chk(32'(pin[0]), 32'h1);
    wr(8'h4c, 32'h0);
    cyc(3);
    chk(32'(pin[0]), 32'h0);
  endtask

  // A masked event leaves the line low; clearing drops it again.
  task automatic t_irq;
    wr(8'h00, 32'h20);
    st(0);
    cyc(3);
    wr(8'h68, 32'h1f);
    st(1);
    cyc(4);
    chk(32'(irq_o), 32'h0);
    rd(8'h68);
    chk(got & 32'h1, 32'h1);
    wr(8'h6c, 32'h1);
    cyc(2);
    chk(32'(irq_o), 32'h1);
    wr(8'h68, 32'h1);
    cyc(2);
    chk(32'(irq_o), 32'h0);
  endtask

  task automatic t_pol;
    for (int i = 0; i < 5; i++)
      wr(8'(4 * i), 32'h1);
    wr(8'h28, 32'h16);
    st(0);
    cyc(3);
    chk(32'(pin), 32'h09);
    rd(8'h70);
    chk(got, 32'h1f);
    st(2);
    cyc(3);
    chk(32'(pin), 32'h16);
    rd(8'h70);
    chk(got, 32'h0);
    wr(8'h28, 32'h0);
  endtask

  task automatic t_delay;
    int   n;
    logic bad;
    wr(8'h04, 32'h20);
    wr(8'h18, 32'h2);
    st(0);
    cyc(40);
    chk(32'(pin[1]), 32'h0);
    st(1);
    wt(1'b1, n);
    chk(32'(n >= 20 && n <= 30), 32'h1);
    st(0);
    cyc(5);
    st(1);
    bad = 1'b0;
    for (int k = 0; k < 40; k++) begin
      cyc(1);
      if (pin[1] !== 1'b1)
        bad = 1'b1;
    end
    chk(32'(bad), 32'h0);
  endtask

  task automatic t_ao;
    @(posedge clk_i);
    src[31:0] <= 32'h4000_8000;
    cyc(4);
    chk(32'(ao1), 32'h1388);
    chk(32'(ao2), 32'h9c4);
    wr(8'h3c, 32'hffce);
    wr(8'h40, 32'h320);
    cyc(4);
    chk(32'(ao1), 32'h157c);
    wr(8'h3c, 32'h64);
    wr(8'h40, 32'h7fff);
    cyc(4);
    chk(32'(ao1), 32'h2710);
    rd(8'h40);
    chk(got, 32'h3e8);
    wr(8'h38, 32'h0);
    wr(8'h44, 32'hffce);
    wr(8'h48, 32'h320);
    cyc(4);
    chk(32'(ao2), 32'h157c);
  endtask

  task automatic t_pulse;
    logic [31:0] c0;
    wr(8'h2c, 32'h0);
    rd(8'h2c);
    chk(got, 32'h1);
    wr(8'h2c, 32'h4e20);
    rd(8'h2c);
    chk(got, 32'h2710);
    @(posedge clk_i);
    src[15:0] <= 16'hffff;
    cyc(100);
    c0 = pcnt;
    cyc(10000);
    chk(32'(pcnt - c0 >= 9 && pcnt - c0 <= 11), 32'h1);
    @(posedge clk_i);
    src[15:0] <= 16'h0;
    cyc(100);
    c0 = pcnt;
    cyc(10000);
    chk(32'(pcnt - c0 <= 1), 32'h1);
  endtask

  initial begin
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset;
    t_codes;
    t_irq;
    t_pol;
    t_delay;
    t_ao;
    t_pulse;
    end_of_test;
  end
endmodule // drive_output_terminal_mapper_tb
